// ### red_bracket.sv
// logic bracket stack depth tracker
`timescale 1ns/100ps
module red_bracket (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // committed bracket operations
  input wire logic push_i,
  input wire logic pop_i,
  // fault indications for the next bracket operation
  output logic over_o,
  output logic under_o
);
  import red_pkg::*;

  logic [2:0] depth_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      depth_reg <= 3'h0;
    end else if (push_i && !over_o) begin
      depth_reg <= depth_reg + 3'h1;
    end else if (pop_i && !under_o) begin
      depth_reg <= depth_reg - 3'h1;
    end
  end

  assign over_o = (depth_reg == BRACKET_MAX);
  assign under_o = (depth_reg == 3'h0);

endmodule // red_bracket

// ### red_dbstate.sv
// state of the currently opened data block
`timescale 1ns/100ps
module red_dbstate (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // open outcomes
  input wire logic open_ok_i,
  input wire logic open_fail_i,
  input wire logic [15:0] len_i,
  // current block
  output logic open_o,
  output logic [15:0] len_o
);
  import red_pkg::*;

  logic open_reg;
  logic [15:0] len_reg;

  // a failed open leaves the base unusable until a good open
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      open_reg <= 1'b0;
      len_reg <= DB_LEN_RESET;
    end else if (open_ok_i) begin
      open_reg <= 1'b1;
      len_reg <= len_i;
    end else if (open_fail_i) begin
      open_reg <= 1'b0;
      len_reg <= DB_LEN_RESET;
    end
  end

  assign open_o = open_reg;
  assign len_o = len_reg;

endmodule // red_dbstate

// ### red_dispatch.sv
// runtime error detection and handler dispatch
`timescale 1ns/100ps
module red_dispatch (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // operation offered by the executing unit
  input wire logic OP_VALID_I,
  input wire red_pkg::red_op_type OP_KIND_I,
  input wire red_pkg::red_size_type OP_SIZE_I,
  input wire logic [15:0] WORD_ADDR_I,
  input wire logic [15:0] PARAM_I,
  input wire logic [15:0] MISC_SUB_I,
  // facts about the addressed block and memory
  input wire logic BLOCK_LOADED_I,
  input wire logic [15:0] BLOCK_LEN_I,
  input wire logic [15:0] HDR_LEN_I,
  input wire logic DEST_EXISTS_I,
  input wire logic MEM_SHORT_I,
  input wire logic COPY_SRC_SHORT_I,
  input wire logic COPY_DST_SHORT_I,
  input wire logic COPY_DST_ROM_I,
  // handler presence and completion
  input wire logic [2:0] HANDLER_LOADED_I,
  input wire logic HANDLER_DONE_I,
  input wire logic HANDLER_STOPPED_I,
  // operation outcome
  output logic OP_READY_O,
  output logic OP_EXECUTE_O,
  output logic OP_SUPPRESS_O,
  output logic RESUME_O,
  // accumulator loads
  output logic ACCU1_WE_O,
  output logic [15:0] ACCU1_O,
  output logic ACCU2_WE_O,
  output logic [15:0] ACCU2_O,
  // handler call
  output logic HANDLER_CALL_O,
  output logic [7:0] HANDLER_NUM_O,
  output red_pkg::red_class_type ERR_CLASS_O,
  // mode and block state
  output logic STOP_O,
  output logic DB_OPEN_O
);
  import red_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCU,
    ST_CALL,
    ST_WAIT,
    ST_STOP
  } red_state_type;

  red_state_type state_reg;
  red_state_type state_next;

  logic err;
  red_class_type err_cls;
  logic [15:0] err_id;
  logic [15:0] err_sub;
  logic err_has_sub;

  logic take;
  logic take_ok;
  logic take_err;

  logic db_open;
  logic [15:0] db_len;
  logic br_over;
  logic br_under;
  logic range_bad;
  logic [16:0] span_last;
  logic word_bad;

  red_class_type cls_reg;
  logic [15:0] sub_reg;
  logic has_sub_reg;
  logic handler_here;

  // ****************************************
  // helpers
  // ****************************************
  red_dbstate i_red_dbstate (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .open_ok_i(take_ok && (OP_KIND_I == OP_OPEN_DB || OP_KIND_I == OP_OPEN_DX)),
    .open_fail_i(take_err && (OP_KIND_I == OP_OPEN_DB || OP_KIND_I == OP_OPEN_DX)),
    .len_i(BLOCK_LEN_I),
    .open_o(db_open),
    .len_o(db_len)
  );

  red_bracket i_red_bracket (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .push_i(take_ok && OP_KIND_I == OP_BRACKET_OPEN),
    .pop_i(take_ok && OP_KIND_I == OP_BRACKET_CLOSE),
    .over_o(br_over),
    .under_o(br_under)
  );

  // ****************************************
  // data word range check
  // ****************************************
  // a double word also needs the following word inside the block
  assign span_last = {1'b0, WORD_ADDR_I} + {16'h0000, OP_SIZE_I == SZ_DWORD};
  assign range_bad = (span_last >= {1'b0, db_len});
  assign word_bad = !db_open || range_bad;

  // ****************************************
  // error detection, first match only
  // ****************************************
  always_comb begin
    err = 1'b0;
    err_cls = CLS_MISC;
    err_id = 16'h0000;
    err_sub = 16'h0000;
    err_has_sub = 1'b0;
    case (OP_KIND_I)
      OP_OPEN_DB, OP_OPEN_DX: begin
        if (!BLOCK_LOADED_I) begin
          err = 1'b1;
          err_cls = CLS_MISSING;
          err_id = (OP_KIND_I == OP_OPEN_DB) ? ID_MISS_DB : ID_MISS_DX;
        end else if (HDR_LEN_I < HDR_MIN) begin
          err = 1'b1;
          err_id = ID_HDR_SHORT;
        end
      end
      OP_CALL_BLOCK, OP_CALL_FX, OP_CLOCK_FN: begin
        if (!BLOCK_LOADED_I) begin
          err = 1'b1;
          err_cls = CLS_MISSING;
          if (OP_KIND_I == OP_CALL_BLOCK) begin
            err_id = ID_MISS_CALL;
          end else if (OP_KIND_I == OP_CALL_FX) begin
            err_id = ID_MISS_FX;
          end else begin
            err_id = ID_MISS_CLOCK;
          end
        end
      end
      OP_SHIFT_FN, OP_MOVE_FN: begin
        if (OP_KIND_I == OP_SHIFT_FN && !BLOCK_LOADED_I) begin
          err = 1'b1;
          err_cls = CLS_MISSING;
          err_id = ID_MISS_SHIFT;
        end else if (DEST_EXISTS_I) begin
          err = 1'b1;
          err_id = ID_DEST_EXISTS;
        end else if (MEM_SHORT_I) begin
          err = 1'b1;
          err_id = ID_FN_MEMORY;
        end
      end
      OP_COPY_FN: begin
        err_id = ID_COPY_PARAM;
        err_has_sub = 1'b1;
        if (!BLOCK_LOADED_I) begin
          err = 1'b1;
          err_cls = CLS_MISSING;
          err_id = ID_MISS_COPY;
          err_has_sub = 1'b0;
        end else if (PARAM_I == 16'h0000 || PARAM_I > MAX_BLOCK_WORDS) begin
          err = 1'b1;
          err_sub = SUB_COPY_COUNT;
        end else if (COPY_SRC_SHORT_I) begin
          err = 1'b1;
          err_sub = SUB_COPY_SRC;
        end else if (COPY_DST_SHORT_I) begin
          err = 1'b1;
          err_sub = SUB_COPY_DST;
        end else if (COPY_DST_ROM_I) begin
          err = 1'b1;
          err_sub = SUB_COPY_ROM;
        end
      end
      OP_DATA_BIT: begin
        if (!db_open || (WORD_ADDR_I >= db_len)) begin
          err = 1'b1;
          err_cls = CLS_LOADXFER;
          err_id = ID_BIT_ACCESS;
        end
      end
      OP_DATA_XFER: begin
        if (word_bad) begin
          err = 1'b1;
          err_cls = CLS_LOADXFER;
          err_id = ID_XFER_BASE + {14'h0000, OP_SIZE_I};
        end
      end
      OP_DATA_LOAD: begin
        if (word_bad) begin
          err = 1'b1;
          err_cls = CLS_LOADXFER;
          err_id = ID_LOAD_BASE + {14'h0000, OP_SIZE_I};
        end
      end
      OP_BDW: begin
        if (!db_open || (WORD_ADDR_I >= db_len)) begin
          err = 1'b1;
          err_cls = CLS_LOADXFER;
          err_id = ID_BDW_ACCESS;
        end
      end
      OP_GEN_DB: begin
        if (DEST_EXISTS_I) begin
          err = 1'b1;
          err_id = ID_GEN_EXISTS;
        end else if (PARAM_I < 16'h0001 || PARAM_I > MAX_BLOCK_WORDS) begin
          err = 1'b1;
          err_id = ID_GEN_COUNT;
        end else if (MEM_SHORT_I) begin
          err = 1'b1;
          err_id = ID_GEN_MEMORY;
        end
      end
      OP_INDEXED_IN: begin
        if (PARAM_I < IDX_MIN || PARAM_I > IDX_MAX) begin
          err = 1'b1;
          err_id = ID_INDEX_PARAM;
        end
      end
      OP_BRACKET_OPEN, OP_BRACKET_CLOSE: begin
        if ((OP_KIND_I == OP_BRACKET_OPEN) ? br_over : br_under) begin
          err = 1'b1;
          err_id = ID_BRACKET;
        end
      end
      OP_PAGE_ACCESS: begin
        if (PARAM_I > PAGE_MAX) begin
          err = 1'b1;
          err_id = ID_PAGE_NUM;
        end
      end
      OP_MISC_FAULT: begin
        // other faults arrive already classified by the caller
        err = 1'b1;
        err_id = PARAM_I;
        err_sub = MISC_SUB_I;
        err_has_sub = (MISC_SUB_I != 16'h0000);
      end
      default: begin
        err = 1'b0;
      end
    endcase
  end

  // ****************************************
  // acceptance
  // ****************************************
  assign OP_READY_O = (state_reg == ST_IDLE);
  assign take = OP_VALID_I && OP_READY_O;
  assign take_ok = take && !err;
  assign take_err = take && err;
  assign handler_here = HANDLER_LOADED_I[cls_reg];

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take_err) begin
          state_next = ST_ACCU;
        end
      end
      ST_ACCU: begin
        state_next = ST_CALL;
      end
      ST_CALL: begin
        state_next = handler_here ? ST_WAIT : ST_STOP;
      end
      ST_WAIT: begin
        if (HANDLER_DONE_I) begin
          state_next = HANDLER_STOPPED_I ? ST_STOP : ST_IDLE;
        end
      end
      ST_STOP: begin
        state_next = ST_STOP;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // captured error
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      cls_reg <= CLS_MISC;
      ACCU1_O <= 16'h0000;
      sub_reg <= 16'h0000;
      has_sub_reg <= 1'b0;
    end else if (take_err) begin
      cls_reg <= err_cls;
      ACCU1_O <= err_id;
      sub_reg <= err_sub;
      has_sub_reg <= err_has_sub;
    end
  end

  // ****************************************
  // operation outcome pulses
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      OP_EXECUTE_O <= 1'b0;
      OP_SUPPRESS_O <= 1'b0;
      RESUME_O <= 1'b0;
    end else begin
      OP_EXECUTE_O <= take_ok;
      OP_SUPPRESS_O <= take_err;
      RESUME_O <= (state_reg == ST_WAIT) && HANDLER_DONE_I && !HANDLER_STOPPED_I;
    end
  end

  // ****************************************
  // accumulator loads
  // ****************************************
  // accumulator two keeps its old value unless a sub-code applies
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ACCU1_WE_O <= 1'b0;
      ACCU2_WE_O <= 1'b0;
      ACCU2_O <= 16'h0000;
    end else begin
      ACCU1_WE_O <= (state_reg == ST_ACCU);
      ACCU2_WE_O <= (state_reg == ST_ACCU) && has_sub_reg;
      if (state_reg == ST_ACCU && has_sub_reg) begin
        ACCU2_O <= sub_reg;
      end
    end
  end

  // ****************************************
  // handler call
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      HANDLER_CALL_O <= 1'b0;
      HANDLER_NUM_O <= 8'h00;
      ERR_CLASS_O <= CLS_MISC;
    end else begin
      HANDLER_CALL_O <= (state_reg == ST_CALL) && handler_here;
      if (state_reg == ST_CALL) begin
        ERR_CLASS_O <= cls_reg;
        case (cls_reg)
          CLS_MISSING: HANDLER_NUM_O <= HND_MISSING;
          CLS_LOADXFER: HANDLER_NUM_O <= HND_LOADXFER;
          default: HANDLER_NUM_O <= HND_MISC;
        endcase
      end
    end
  end

  // ****************************************
  // stop mode
  // ****************************************
  // only a reset leaves stop; a restart is the owner's business
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      STOP_O <= 1'b0;
    end else if (state_next == ST_STOP) begin
      STOP_O <= 1'b1;
    end
  end

  assign DB_OPEN_O = db_open;

endmodule // red_dispatch

// ### red_dispatch_checker.sv
// port-level assertions for the runtime error dispatch block
`timescale 1ns/100ps
module red_dispatch_checker (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // operation and handler inputs
  input wire logic OP_VALID_I,
  input wire logic [2:0] HANDLER_LOADED_I,
  input wire logic HANDLER_DONE_I,
  input wire logic HANDLER_STOPPED_I,
  // outcomes
  input wire logic OP_READY_O,
  input wire logic OP_EXECUTE_O,
  input wire logic OP_SUPPRESS_O,
  input wire logic RESUME_O,
  input wire logic ACCU1_WE_O,
  input wire logic [15:0] ACCU1_O,
  input wire logic ACCU2_WE_O,
  input wire logic [15:0] ACCU2_O,
  input wire logic HANDLER_CALL_O,
  input wire logic [7:0] HANDLER_NUM_O,
  input wire red_pkg::red_class_type ERR_CLASS_O,
  input wire logic STOP_O
);
  import red_pkg::*;
  // ****************************************
  // handler wait tracking
  // ****************************************
  // done only counts once a handler has actually been called
  logic waiting_reg;
  logic waiting_next;
  always_comb begin
    waiting_next = HANDLER_CALL_O ? 1'b1 : (HANDLER_DONE_I ? 1'b0 : waiting_reg);
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      waiting_reg <= 1'b0;
    end else begin
      waiting_reg <= waiting_next;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence take_s;
    OP_VALID_I && OP_READY_O;
  endsequence
  sequence load_id_s;
    ACCU1_WE_O;
  endsequence
  sequence dispatch_s;
    HANDLER_CALL_O ^ STOP_O;
  endsequence
  one_outcome_a: assert property (take_s |=> OP_EXECUTE_O != OP_SUPPRESS_O)
    else $error("take without exactly one outcome");
  error_steps_a: assert property (OP_SUPPRESS_O |-> !OP_READY_O ##1 load_id_s ##1 dispatch_s)
    else $error("error sequence out of order");
  loaded_call_a: assert property (load_id_s |=> HANDLER_CALL_O == HANDLER_LOADED_I[ERR_CLASS_O])
    else $error("handler call does not follow handler presence");
  handler_num_a: assert property (HANDLER_CALL_O |-> HANDLER_NUM_O ==
    (ERR_CLASS_O == CLS_MISSING ? HND_MISSING :
    (ERR_CLASS_O == CLS_LOADXFER ? HND_LOADXFER : HND_MISC)))
    else $error("wrong handler number for class");
  missing_id_a: assert property (HANDLER_CALL_O && ERR_CLASS_O == CLS_MISSING |->
    ACCU1_O inside {[ID_MISS_DB:ID_MISS_CLOCK]}) else $error("missing-block id out of range");
  xfer_id_a: assert property (HANDLER_CALL_O && ERR_CLASS_O == CLS_LOADXFER |->
    ACCU1_O inside {[ID_BIT_ACCESS:ID_BDW_ACCESS]}) else $error("load/transfer id out of range");
  resume_next_a: assert property (waiting_reg && HANDLER_DONE_I && !HANDLER_STOPPED_I |=>
    RESUME_O && OP_READY_O && !STOP_O) else $error("no resume after handler");
  handler_stop_a: assert property (waiting_reg && HANDLER_DONE_I && HANDLER_STOPPED_I |=>
    STOP_O && !RESUME_O) else $error("handler stop not honoured");
  stop_holds_a: assert property (STOP_O |-> !OP_READY_O ##1 STOP_O)
    else $error("stop mode left or ready in stop");
  sub_code_a: assert property (ACCU2_WE_O |-> ACCU1_WE_O && ACCU2_O != 16'h0000)
    else $error("sub-code written alone or empty");
endmodule // red_dispatch_checker

bind red_dispatch red_dispatch_checker i_red_dispatch_checker (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .OP_VALID_I(OP_VALID_I),
  .HANDLER_LOADED_I(HANDLER_LOADED_I), .HANDLER_DONE_I(HANDLER_DONE_I),
  .HANDLER_STOPPED_I(HANDLER_STOPPED_I), .OP_READY_O(OP_READY_O),
  .OP_EXECUTE_O(OP_EXECUTE_O), .OP_SUPPRESS_O(OP_SUPPRESS_O), .RESUME_O(RESUME_O),
  .ACCU1_WE_O(ACCU1_WE_O), .ACCU1_O(ACCU1_O), .ACCU2_WE_O(ACCU2_WE_O), .ACCU2_O(ACCU2_O),
  .HANDLER_CALL_O(HANDLER_CALL_O), .HANDLER_NUM_O(HANDLER_NUM_O),
  .ERR_CLASS_O(ERR_CLASS_O), .STOP_O(STOP_O));

// ### red_pkg.sv
// shared constants and types of the runtime error dispatch block
package red_pkg;

  // ****************************************
  // operation kinds offered for checking
  // ****************************************
  typedef enum logic [4:0] {
    OP_PLAIN,
    OP_OPEN_DB,
    OP_OPEN_DX,
    OP_CALL_BLOCK,
    OP_CALL_FX,
    OP_SHIFT_FN,
    OP_MOVE_FN,
    OP_COPY_FN,
    OP_CLOCK_FN,
    OP_DATA_BIT,
    OP_DATA_XFER,
    OP_DATA_LOAD,
    OP_BDW,
    OP_GEN_DB,
    OP_INDEXED_IN,
    OP_BRACKET_OPEN,
    OP_BRACKET_CLOSE,
    OP_PAGE_ACCESS,
    OP_MISC_FAULT
  } red_op_type;

  typedef enum logic [1:0] {
    SZ_RIGHT_BYTE,
    SZ_LEFT_BYTE,
    SZ_WORD,
    SZ_DWORD
  } red_size_type;

  typedef enum logic [1:0] {
    CLS_MISSING,
    CLS_LOADXFER,
    CLS_MISC
  } red_class_type;

  // ****************************************
  // handler numbers
  // ****************************************
  localparam logic [7:0] HND_MISSING = 8'h13;
  localparam logic [7:0] HND_MISC = 8'h1F;
  localparam logic [7:0] HND_LOADXFER = 8'h20;

  // ****************************************
  // identifiers and sub-codes
  // ****************************************
  localparam logic [15:0] ID_MISS_DB = 16'h1A01;
  localparam logic [15:0] ID_MISS_DX = 16'h1A02;
  localparam logic [15:0] ID_MISS_CALL = 16'h1A03;
  localparam logic [15:0] ID_MISS_FX = 16'h1A04;
  localparam logic [15:0] ID_MISS_SHIFT = 16'h1A05;
  localparam logic [15:0] ID_MISS_COPY = 16'h1A06;
  localparam logic [15:0] ID_MISS_CLOCK = 16'h1A07;
  localparam logic [15:0] ID_BIT_ACCESS = 16'h1A11;
  localparam logic [15:0] ID_XFER_BASE = 16'h1A12;
  localparam logic [15:0] ID_LOAD_BASE = 16'h1A16;
  localparam logic [15:0] ID_BDW_ACCESS = 16'h1A1A;
  localparam logic [15:0] ID_GEN_EXISTS = 16'h1A21;
  localparam logic [15:0] ID_GEN_COUNT = 16'h1A22;
  localparam logic [15:0] ID_GEN_MEMORY = 16'h1A23;
  localparam logic [15:0] ID_INDEX_PARAM = 16'h1A25;
  localparam logic [15:0] ID_BRACKET = 16'h1A29;
  localparam logic [15:0] ID_HDR_SHORT = 16'h1A2A;
  localparam logic [15:0] ID_PAGE_NUM = 16'h1A2C;
  localparam logic [15:0] ID_DEST_EXISTS = 16'h1A31;
  localparam logic [15:0] ID_FN_MEMORY = 16'h1A33;
  localparam logic [15:0] ID_COPY_PARAM = 16'h1A34;
  localparam logic [15:0] SUB_COPY_COUNT = 16'h0220;
  localparam logic [15:0] SUB_COPY_SRC = 16'h0221;
  localparam logic [15:0] SUB_COPY_DST = 16'h0222;
  localparam logic [15:0] SUB_COPY_ROM = 16'h0223;

  // ****************************************
  // limits
  // ****************************************
  localparam logic [15:0] MAX_BLOCK_WORDS = 16'h0FFB;
  localparam logic [15:0] IDX_MIN = 16'h0001;
  localparam logic [15:0] IDX_MAX = 16'h007D;
  localparam logic [15:0] PAGE_MAX = 16'h00FF;
  localparam logic [15:0] HDR_MIN = 16'h0005;
  localparam logic [2:0] BRACKET_MAX = 3'h7;
  localparam logic [15:0] DB_LEN_RESET = 16'h0000;

endpackage

// ### tb_red_dispatch.sv
// self-checking testbench of the runtime error dispatch block
`timescale 1ns/100ps
module tb_red_dispatch;
  import red_pkg::*;
  logic MCLK_I, RST_N_I, OP_VALID_I, BLOCK_LOADED_I, DEST_EXISTS_I, MEM_SHORT_I;
  logic COPY_SRC_SHORT_I, COPY_DST_SHORT_I, COPY_DST_ROM_I, HANDLER_DONE_I, HANDLER_STOPPED_I;
  red_op_type OP_KIND_I;
  red_size_type OP_SIZE_I;
  logic [15:0] WORD_ADDR_I, PARAM_I, MISC_SUB_I, BLOCK_LEN_I, HDR_LEN_I, ACCU1_O, ACCU2_O;
  logic [2:0] HANDLER_LOADED_I;
  logic OP_READY_O, OP_EXECUTE_O, OP_SUPPRESS_O, RESUME_O, ACCU1_WE_O, ACCU2_WE_O;
  logic HANDLER_CALL_O, STOP_O, DB_OPEN_O;
  logic [7:0] HANDLER_NUM_O;
  red_class_type ERR_CLASS_O;
  int mismatches, n_compared, i;
  logic [23:0] q[$];
  logic [15:0] qs[$];
  logic [23:0] e;
  logic [7:0] pend_h;
  logic [15:0] len, a;
  red_op_type mk [7] = '{OP_OPEN_DB, OP_OPEN_DX, OP_CALL_BLOCK, OP_CALL_FX, OP_SHIFT_FN,
    OP_COPY_FN, OP_CLOCK_FN};
  red_op_type pk [10] = '{OP_GEN_DB, OP_GEN_DB, OP_GEN_DB, OP_GEN_DB, OP_INDEXED_IN,
    OP_INDEXED_IN, OP_INDEXED_IN, OP_INDEXED_IN, OP_PAGE_ACCESS, OP_PAGE_ACCESS};
  logic [15:0] pv [10] = '{16'h0000, MAX_BLOCK_WORDS + 16'h0001, MAX_BLOCK_WORDS, 16'h0001,
    IDX_MIN - 16'h0001, IDX_MAX + 16'h0001, IDX_MIN, IDX_MAX, PAGE_MAX + 16'h0001, PAGE_MAX};
  logic [15:0] pe [10] = '{ID_GEN_COUNT, ID_GEN_COUNT, 16'h0000, 16'h0000, ID_INDEX_PARAM,
    ID_INDEX_PARAM, 16'h0000, 16'h0000, ID_PAGE_NUM, 16'h0000};

  red_dispatch i_red_dispatch (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .OP_VALID_I(OP_VALID_I), .OP_KIND_I(OP_KIND_I),
    .OP_SIZE_I(OP_SIZE_I), .WORD_ADDR_I(WORD_ADDR_I), .PARAM_I(PARAM_I),
    .MISC_SUB_I(MISC_SUB_I), .BLOCK_LOADED_I(BLOCK_LOADED_I), .BLOCK_LEN_I(BLOCK_LEN_I),
    .HDR_LEN_I(HDR_LEN_I), .DEST_EXISTS_I(DEST_EXISTS_I), .MEM_SHORT_I(MEM_SHORT_I),
    .COPY_SRC_SHORT_I(COPY_SRC_SHORT_I), .COPY_DST_SHORT_I(COPY_DST_SHORT_I),
    .COPY_DST_ROM_I(COPY_DST_ROM_I), .HANDLER_LOADED_I(HANDLER_LOADED_I),
    .HANDLER_DONE_I(HANDLER_DONE_I), .HANDLER_STOPPED_I(HANDLER_STOPPED_I),
    .OP_READY_O(OP_READY_O), .OP_EXECUTE_O(OP_EXECUTE_O), .OP_SUPPRESS_O(OP_SUPPRESS_O),
    .RESUME_O(RESUME_O), .ACCU1_WE_O(ACCU1_WE_O), .ACCU1_O(ACCU1_O),
    .ACCU2_WE_O(ACCU2_WE_O), .ACCU2_O(ACCU2_O), .HANDLER_CALL_O(HANDLER_CALL_O),
    .HANDLER_NUM_O(HANDLER_NUM_O), .ERR_CLASS_O(ERR_CLASS_O), .STOP_O(STOP_O),
    .DB_OPEN_O(DB_OPEN_O));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (q.size() != 0 || qs.size() != 0) mismatches++;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    RST_N_I <= 1'b0;
    repeat (6) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
  endtask

  // h: 0 good op, 1 stop expected, else handler number; called at a rising edge
  task automatic op(input red_op_type k, input red_size_type s, input logic [15:0] ad,
                    input logic [15:0] p, input logic [15:0] id, input logic [7:0] h);
    int n;
    red_class_type c;
    q.push_back({h, id});
    OP_VALID_I <= 1'b1;
    OP_KIND_I <= k;
    OP_SIZE_I <= s;
    WORD_ADDR_I <= ad;
    PARAM_I <= p;
    n = 0;
    @(negedge MCLK_I);
    while (OP_READY_O !== 1'b1 && n < 50) begin
      @(negedge MCLK_I);
      n++;
    end
    @(posedge MCLK_I);
    if (h != 8'h00) begin
      OP_VALID_I <= 1'b0;
      n = 0;
      @(negedge MCLK_I);
      check(16'(OP_SUPPRESS_O), 16'h0001);
      while (HANDLER_CALL_O !== 1'b1 && STOP_O !== 1'b1 && n < 10) begin
        @(negedge MCLK_I);
        n++;
      end
      check(16'(STOP_O), 16'(h == 8'h01));
      c = (h == HND_LOADXFER) ? CLS_LOADXFER : CLS_MISC;
      if (h == HND_MISSING) c = CLS_MISSING;
      check(16'(ERR_CLASS_O), 16'(c));
      if (h != 8'h01) begin
        @(posedge MCLK_I);
        HANDLER_DONE_I <= 1'b1;
        @(posedge MCLK_I);
        HANDLER_DONE_I <= 1'b0;
        @(negedge MCLK_I);
        check(16'(RESUME_O), 16'(!HANDLER_STOPPED_I));
        @(posedge MCLK_I);
      end
    end
  endtask

  // ****************************************
  // result monitor
  // ****************************************
  always @(posedge MCLK_I) begin
    if (OP_EXECUTE_O === 1'b1 || ACCU1_WE_O === 1'b1) begin
      e = (q.size() != 0) ? q.pop_front() : 24'hFFFFFF;
      check(ACCU1_WE_O === 1'b1 ? ACCU1_O : 16'h0000, e[15:0]);
      pend_h = e[23:16];
    end
    if (ACCU2_WE_O === 1'b1) check(ACCU2_O, qs.size() != 0 ? qs.pop_front() : 16'hFFFF);
    if (HANDLER_CALL_O === 1'b1) check(16'(HANDLER_NUM_O), 16'(pend_h));
  end

  initial begin
    MCLK_I = 1'b0;
    forever #10 MCLK_I = ~MCLK_I;
  end

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #400000;
    mismatches++;
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {OP_VALID_I, HANDLER_DONE_I, HANDLER_STOPPED_I, DEST_EXISTS_I, MEM_SHORT_I} = '0;
    {COPY_SRC_SHORT_I, COPY_DST_SHORT_I, COPY_DST_ROM_I, RST_N_I} = '0;
    {WORD_ADDR_I, PARAM_I, MISC_SUB_I, BLOCK_LEN_I} = '0;
    OP_KIND_I = OP_PLAIN;
    OP_SIZE_I = SZ_WORD;
    BLOCK_LOADED_I = 1'b1;
    HDR_LEN_I = HDR_MIN;
    HANDLER_LOADED_I = 3'h7;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'h38f52456));
    do_reset();
    check(ACCU1_O | 16'(HANDLER_NUM_O) | 16'(STOP_O) | 16'(DB_OPEN_O), 16'h0000);
    op(OP_PLAIN, SZ_WORD, '0, '0, '0, '0);
    op(OP_PLAIN, SZ_WORD, '0, '0, '0, '0);
    for (i = 0; i < 4; i++) op(OP_DATA_XFER, red_size_type'(i), '0, '0, ID_XFER_BASE + 16'(i),
      HND_LOADXFER);
    len = 16'(8 + $urandom_range(90));
    BLOCK_LEN_I <= len;
    op(OP_OPEN_DB, SZ_WORD, '0, '0, '0, '0);
    for (i = 0; i < 6; i++) op(OP_DATA_XFER, SZ_DWORD, 16'($urandom_range(len - 2)), '0, '0, '0);
    op(OP_DATA_XFER, SZ_WORD, len - 16'h0001, '0, '0, '0);
    op(OP_DATA_XFER, SZ_DWORD, len - 16'h0001, '0, ID_XFER_BASE + 16'h0003, HND_LOADXFER);
    for (i = 0; i < 4; i++) op(OP_DATA_LOAD, red_size_type'(i), len, '0, ID_LOAD_BASE + 16'(i),
      HND_LOADXFER);
    op(OP_DATA_BIT, SZ_WORD, len, '0, ID_BIT_ACCESS, HND_LOADXFER);
    op(OP_DATA_BIT, SZ_WORD, len - 16'h0001, '0, '0, '0);
    op(OP_BDW, SZ_WORD, len, '0, ID_BDW_ACCESS, HND_LOADXFER);
    check(16'(DB_OPEN_O), 16'h0001);
    HDR_LEN_I <= HDR_MIN - 16'h0001;
    op(OP_OPEN_DB, SZ_WORD, '0, '0, ID_HDR_SHORT, HND_MISC);
    HDR_LEN_I <= HDR_MIN;
    op(OP_DATA_LOAD, SZ_WORD, '0, '0, ID_LOAD_BASE + 16'h0002, HND_LOADXFER);
    check(16'(DB_OPEN_O), 16'h0000);
    BLOCK_LOADED_I <= 1'b0;
    for (i = 0; i < 7; i++) op(mk[i], SZ_WORD, '0, '0, ID_MISS_DB + 16'(i), HND_MISSING);
    op(OP_MOVE_FN, SZ_WORD, '0, '0, '0, '0);
    for (i = 0; i < 10; i++) op(pk[i], SZ_WORD, '0, pv[i], pe[i],
      pe[i] != 16'h0000 ? HND_MISC : 8'h00);
    MEM_SHORT_I <= 1'b1;
    op(OP_GEN_DB, SZ_WORD, '0, 16'h000A, ID_GEN_MEMORY, HND_MISC);
    MEM_SHORT_I <= 1'b0;
    BLOCK_LOADED_I <= 1'b1;
    for (i = 0; i < 16; i++) op(i < 8 ? OP_BRACKET_OPEN : OP_BRACKET_CLOSE, SZ_WORD, '0, '0,
      i % 8 == 7 ? ID_BRACKET : 16'h0000, i % 8 == 7 ? HND_MISC : 8'h00);
    DEST_EXISTS_I <= 1'b1;
    op(OP_SHIFT_FN, SZ_WORD, '0, '0, ID_DEST_EXISTS, HND_MISC);
    DEST_EXISTS_I <= 1'b0;
    MEM_SHORT_I <= 1'b1;
    op(OP_MOVE_FN, SZ_WORD, '0, '0, ID_FN_MEMORY, HND_MISC);
    MEM_SHORT_I <= 1'b0;
    for (i = 0; i < 4; i++) begin
      {COPY_DST_ROM_I, COPY_DST_SHORT_I, COPY_SRC_SHORT_I} <= 3'(i == 0 ? 0 : 1 << (i - 1));
      qs.push_back(SUB_COPY_COUNT + 16'(i));
      op(OP_COPY_FN, SZ_WORD, '0, 16'(i == 0 ? 0 : 10), ID_COPY_PARAM, HND_MISC);
    end
    {COPY_DST_ROM_I, COPY_DST_SHORT_I, COPY_SRC_SHORT_I} <= '0;
    op(OP_COPY_FN, SZ_WORD, '0, 16'h000A, '0, '0);
    a = 16'($urandom_range(16'hFFFE) + 1);
    MISC_SUB_I <= a;
    qs.push_back(a);
    op(OP_MISC_FAULT, SZ_WORD, '0, 16'h1A2B, 16'h1A2B, HND_MISC);
    MISC_SUB_I <= '0;
    op(OP_MISC_FAULT, SZ_WORD, '0, 16'h1A2B, 16'h1A2B, HND_MISC);
    BLOCK_LOADED_I <= 1'b0;
    HANDLER_STOPPED_I <= 1'b1;
    op(OP_CALL_BLOCK, SZ_WORD, '0, '0, ID_MISS_CALL, HND_MISSING);
    @(negedge MCLK_I);
    check({15'h0000, STOP_O}, 16'h0001);
    @(posedge MCLK_I);
    do_reset();
    HANDLER_STOPPED_I <= 1'b0;
    HANDLER_LOADED_I <= 3'h3;
    op(OP_MISC_FAULT, SZ_WORD, '0, 16'h1A2B, 16'h1A2B, 8'h01);
    repeat (3) @(posedge MCLK_I);
    check({15'h0000, OP_READY_O}, 16'h0000);
    results();
  end
endmodule // tb_red_dispatch
